/* src/bfss_defs.svh */
// Constants for the bridge fault and sleep supervisor
// Function
// - Ignore the current comparator for about 1 us after each drive start.
// - That masking time is also the least drive time of each PWM cycle.
// - On a current trip, decay for the selected off-time, then drive again.
// - Hold the open-drain fault output low during any fault; released after power-up.
// - Supply undervoltage disables all bridges, the charge pump, and flags a fault.
// - Supply undervoltage recovers by itself when the supply returns.
// - Pump undervoltage disables all bridges and flags a fault; the pump keeps running.
// - Pump undervoltage recovers by itself when the rail returns.
// - Current limit beyond the filter time disables that bridge only; pump stays on.
// - Overcurrent stays latched until a sleep reset pulse or power cycle.
// - Overtemperature disables all bridges and the pump and flags a fault.
// - Overtemperature stays latched; a reset pulse clears it only once cooled.
// - While asleep, all transistors and the charge pump are off.
// - Sleep is entered only after the entry delay following a falling sleep pin.
// - A high sleep pin wakes the device; inputs wait for the settle time.
// - Active only with the sleep pin high and the supply above threshold.
// - A low pulse longer than 20 us and shorter than 40 us clears latched faults.
// - Low times from 40 to 120 us also clear faults; sleep may or may not follow.
// - Bridges are off while the pin is low; otherwise a clearing pulse touches only the fault latches.
`ifndef BFSS_DEFS_SVH
`define BFSS_DEFS_SVH
`define BFSS_CLK_NS        50
`define BFSS_MASK_NS       1000
`define BFSS_MASK_CYC      ((`BFSS_MASK_NS + `BFSS_CLK_NS - 1) / `BFSS_CLK_NS)
`define BFSS_OCP_FILT_NS   2000
`define BFSS_OCP_FILT_CYC  ((`BFSS_OCP_FILT_NS + `BFSS_CLK_NS - 1) / `BFSS_CLK_NS)
`define BFSS_CLR_MIN_US    20
`define BFSS_CLR_MAX_US    120
`define BFSS_CLR_MIN_CYC   ((`BFSS_CLR_MIN_US * 1000 + `BFSS_CLK_NS - 1) / `BFSS_CLK_NS)
`define BFSS_CLR_MAX_CYC   ((`BFSS_CLR_MAX_US * 1000) / `BFSS_CLK_NS)
`define BFSS_SLEEP_US      80
`define BFSS_SLEEP_CYC     ((`BFSS_SLEEP_US * 1000 + `BFSS_CLK_NS - 1) / `BFSS_CLK_NS)
`define BFSS_WAKE_US       200
`define BFSS_WAKE_CYC      ((`BFSS_WAKE_US * 1000 + `BFSS_CLK_NS - 1) / `BFSS_CLK_NS)
`define BFSS_TOFF0_NS      7000
`define BFSS_TOFF1_NS      16000
`define BFSS_TOFF2_NS      24000
`define BFSS_TOFF3_NS      32000
`define BFSS_DECAY_INTERVAL_CYC(ns)  (((ns) + `BFSS_CLK_NS - 1) / `BFSS_CLK_NS)
`endif

/* src/bfss_pkg.sv */
// Types for the bridge fault and sleep supervisor
package bfss_pkg;
    typedef enum logic [1:0] {
        BFSS_IDLE  = 2'h0,
        BFSS_MASK  = 2'h1,
        BFSS_DRIVE = 2'h2,
        BFSS_DECAY = 2'h3
    } bfss_pwm_e;
    typedef logic [11:0] bfss_cnt_t;
endpackage : bfss_pkg

/* src/bfss_supervisor.sv */
// Fault, blanking, off-time and sleep supervision for a dual H-bridge
`timescale 1ns/10ps
`include "bfss_defs.svh"
module bfss_supervisor
    import bfss_pkg::*;
#(
    parameter int OCP_FILT_CYC = `BFSS_OCP_FILT_CYC,
    parameter int SLEEP_CYC    = `BFSS_SLEEP_CYC
)(
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       reset_i,
    // Pins and analog comparators
    input  wire logic       low_power_req_n_i,
    input  wire logic       supply_undervolt_i,
    input  wire logic       pump_undervolt_i,
    input  wire logic       overtemp_shutdown_i,
    input  wire logic [1:0] ilim_i,
    input  wire logic [1:0] trip_i,
    // Bridge control from the input decoder
    input  wire logic [1:0] drive_req_i,
    input  wire logic [1:0] decay_sel_i,
    // Bridge and pump control
    output logic      [1:0] bridge_drive_o,
    output logic      [1:0] bridge_decay_o,
    output logic            pump_en_o,
    output logic            asleep_o,
    output logic            ready_o,
    // Status
    output logic      [1:0] overcurrent_trip_o,
    output logic            overtemp_shutdown_o,
    output logic            fault_clear_o,
    output logic            fault_flag_out_o,
    output logic            fault_flag_out_oe_o
);
    localparam bfss_cnt_t MASK_CYC  = 12'(`BFSS_MASK_CYC);
    localparam bfss_cnt_t CLR_MIN   = 12'(`BFSS_CLR_MIN_CYC);
    localparam bfss_cnt_t CLR_MAX   = 12'(`BFSS_CLR_MAX_CYC);
    localparam bfss_cnt_t WAKE_CYC  = 12'(`BFSS_WAKE_CYC);
    localparam bfss_cnt_t SLEEP_LIM = 12'(SLEEP_CYC);
    localparam bfss_cnt_t OCP_LIM   = 12'(OCP_FILT_CYC);

    // Counters are twelve bits wide; larger counts would wrap
    if (SLEEP_CYC < 1 || SLEEP_CYC > 4095 ||
        OCP_FILT_CYC < 1 || OCP_FILT_CYC > 4095) begin : g_chk
        $error("bfss_supervisor: counts must lie in 1..4095");
    end

    // Off-time in cycles for a decay selection
    function automatic bfss_cnt_t decay_interval_cyc(input logic [1:0] sel);
        bfss_cnt_t c;
        c = 12'(`BFSS_DECAY_INTERVAL_CYC(`BFSS_TOFF0_NS));
        if (sel == 2'h1) c = 12'(`BFSS_DECAY_INTERVAL_CYC(`BFSS_TOFF1_NS));
        if (sel == 2'h2) c = 12'(`BFSS_DECAY_INTERVAL_CYC(`BFSS_TOFF2_NS));
        if (sel == 2'h3) c = 12'(`BFSS_DECAY_INTERVAL_CYC(`BFSS_TOFF3_NS));
        return c;
    endfunction : decay_interval_cyc

    // Three-stage pin synchronisers; a change counts when stages two and three agree.
    // The sleep pin stages reset to its idle high level, so that no false low
    // time and no false rising edge follow reset.
    logic [7:0] s1_r, s2_r, s3_r, flt_r;
    wire  [7:0] pins    = {trip_i, ilim_i, overtemp_shutdown_i, pump_undervolt_i,
                           supply_undervolt_i, low_power_req_n_i};
    wire  [7:0] flt_nxt = (s2_r & s3_r) | (flt_r & (s2_r ^ s3_r));
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            s1_r  <= 8'h01;
            s2_r  <= 8'h01;
            s3_r  <= 8'h01;
            flt_r <= 8'h01;
        end else begin
            s1_r  <= pins;
            s2_r  <= s1_r;
            s3_r  <= s2_r;
            flt_r <= flt_nxt;
        end
    end
    wire       wake_pin = flt_r[0];
    wire       uv       = flt_r[1];
    wire       pump_undervolt     = flt_r[2];
    wire       ot       = flt_r[3];
    wire [1:0] ilim     = flt_r[5:4];
    wire [1:0] trip     = flt_r[7:6];

    // Sleep pin timing: entry delay, wake settle and reset pulse decode
    bfss_cnt_t low_cnt_r, wake_cnt_r;
    logic      wake_pin_d_r, asleep_r;
    wire pin_rose  = wake_pin & ~wake_pin_d_r;
    wire clr_pulse = pin_rose && low_cnt_r > CLR_MIN && low_cnt_r < CLR_MAX;
    wire sleep_hit = ~wake_pin && low_cnt_r >= SLEEP_LIM - 12'h001;
    wire settled   = wake_cnt_r >= WAKE_CYC;
    // Low time saturates so a very long sleep never looks like a short pulse
    bfss_cnt_t low_cnt_nxt, wake_cnt_nxt;
    assign low_cnt_nxt  = wake_pin ? 12'h000 :
                          (low_cnt_r == 12'hFFF ? low_cnt_r : low_cnt_r + 12'h001);
    // Settle time restarts after sleep or supply loss
    assign wake_cnt_nxt = (asleep_r || uv) ? 12'h000 :
                          (settled ? wake_cnt_r : wake_cnt_r + 12'h001);
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            low_cnt_r    <= 12'h000;
            wake_cnt_r   <= 12'h000;
            wake_pin_d_r <= 1'b1;
            asleep_r     <= 1'b0;
        end else begin
            wake_pin_d_r <= wake_pin;
            low_cnt_r    <= low_cnt_nxt;
            asleep_r     <= wake_pin ? 1'b0 : (asleep_r | sleep_hit);
            wake_cnt_r   <= wake_cnt_nxt;
        end
    end

    // Fault latches; a new event wins over a clearing pulse
    logic [1:0] ocp_lat_r;
    logic       ot_lat_r;
    bfss_cnt_t  ocp_cnt_r [2];
    bfss_pwm_e  st_r [2];
    logic [1:0] ocp_set;
    for (genvar b = 0; b < 2; b++) begin : g_ocp
        assign ocp_set[b] = ilim[b] && ocp_cnt_r[b] >= OCP_LIM - 12'h001;
    end
    wire ot_clr = clr_pulse & ~ot;
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            ocp_lat_r <= 2'h0;
            ot_lat_r  <= 1'b0;
            ocp_cnt_r <= '{12'h000, 12'h000};
        end else begin
            ocp_lat_r <= ocp_set | (ocp_lat_r & {2{~clr_pulse}});
            ot_lat_r  <= ot | (ot_lat_r & ~ot_clr);
            for (int b = 0; b < 2; b++) begin
                ocp_cnt_r[b] <= ilim[b] ? ocp_cnt_r[b] + 12'h001 : 12'h000;
            end
        end
    end

    // Operating conditions
    wire active    = wake_pin & ~uv & ~asleep_r & settled;
    // Supply faults block only while present, so recovery needs no action
    wire all_block = uv | pump_undervolt | ot_lat_r;
    wire fault_any = uv | pump_undervolt | (|ocp_lat_r) | ot_lat_r;
    wire [1:0] en_ok = drive_req_i & ~ocp_lat_r & {2{active & ~all_block}};

    // Per-bridge off-time PWM with blanking
    bfss_pwm_e st_nxt [2];
    bfss_cnt_t cnt_r [2];
    bfss_cnt_t cnt_nxt [2];
    always_comb begin
        for (int b = 0; b < 2; b++) begin
            st_nxt[b]  = st_r[b];
            cnt_nxt[b] = cnt_r[b] + 12'h001;
            unique case (st_r[b])
                BFSS_IDLE: begin
                    cnt_nxt[b] = 12'h000;
                    if (en_ok[b]) st_nxt[b] = BFSS_MASK;
                end
                BFSS_MASK: begin
                    // Comparator is not looked at here
                    if (cnt_r[b] >= MASK_CYC - 12'h001) st_nxt[b] = BFSS_DRIVE;
                end
                BFSS_DRIVE: begin
                    cnt_nxt[b] = 12'h000;
                    if (trip[b]) st_nxt[b] = BFSS_DECAY;
                end
                BFSS_DECAY: begin
                    if (cnt_r[b] >= decay_interval_cyc(decay_sel_i) - 12'h001) begin
                        st_nxt[b]  = BFSS_MASK;
                        cnt_nxt[b] = 12'h000;
                    end
                end
            endcase
            if (!en_ok[b]) begin
                st_nxt[b]  = BFSS_IDLE;
                cnt_nxt[b] = 12'h000;
            end
        end
    end
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            st_r  <= '{BFSS_IDLE, BFSS_IDLE};
            cnt_r <= '{12'h000, 12'h000};
        end else begin
            st_r  <= st_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // Outputs
    for (genvar b = 0; b < 2; b++) begin : g_out
        assign bridge_drive_o[b] = st_r[b] == BFSS_MASK || st_r[b] == BFSS_DRIVE;
        assign bridge_decay_o[b] = st_r[b] == BFSS_DECAY;
    end
    assign pump_en_o           = ~asleep_r & ~uv & ~ot_lat_r;
    assign asleep_o            = asleep_r;
    assign ready_o             = active;
    assign overcurrent_trip_o  = ocp_lat_r;
    assign overtemp_shutdown_o = ot_lat_r;
    assign fault_clear_o       = clr_pulse;
    assign fault_flag_out_o    = 1'b0;
    assign fault_flag_out_oe_o = fault_any;

    // Checks
    bfss_cnt_t on_cnt_r;
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) on_cnt_r <= 12'h000;
        else on_cnt_r <= bridge_drive_o[0] ? on_cnt_r + 12'h001 : 12'h000;
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    AST_MASK: assert property (st_r[0] == BFSS_MASK |=> st_r[0] != BFSS_DECAY)
        else $error("decay entered during blanking");
    AST_MINON: assert property ($rose(bridge_decay_o[0]) |-> $past(on_cnt_r) >= 12'd19)
        else $error("drive phase shorter than blanking");
    AST_DECAY: assert property (st_r[0] == BFSS_DRIVE && trip[0] && en_ok[0]
        |=> bridge_decay_o[0])
        else $error("trip did not start decay");
    AST_FLAG: assert property (fault_flag_out_oe_o == (uv | pump_undervolt | (|ocp_lat_r) | ot_lat_r)
        && !fault_flag_out_o)
        else $error("fault output does not follow faults");
    AST_UV: assert property (uv |-> !pump_en_o ##1 bridge_drive_o == 2'h0)
        else $error("undervoltage left pump or bridge on");
    AST_UV_REC: assert property ($fell(uv) && !pump_undervolt && !ot_lat_r && ocp_lat_r == 2'h0
        |-> !fault_flag_out_oe_o)
        else $error("undervoltage did not release fault");
    AST_PUMP_UNDERVOLT: assert property (pump_undervolt && !asleep_r && !uv && !ot_lat_r
        |-> pump_en_o ##1 bridge_drive_o == 2'h0)
        else $error("pump undervoltage handling wrong");
    AST_OCP_SET: assert property (ocp_set[0] |=> ocp_lat_r[0] ##1 !bridge_drive_o[0])
        else $error("overcurrent not latched");
    AST_OCP_SET1: assert property (ocp_set[1] |=> ocp_lat_r[1] ##1 !bridge_drive_o[1])
        else $error("overcurrent not latched on bridge one");
    AST_OCP_PUMP: assert property (ocp_lat_r != 2'h0 && !asleep_r && !uv && !ot_lat_r
        |-> pump_en_o)
        else $error("overcurrent stopped the pump");
    AST_OCP_HOLD1: assert property (ocp_lat_r[1] && !clr_pulse |=> ocp_lat_r[1])
        else $error("overcurrent latch lost on bridge one");
    AST_OCP_CLR: assert property (clr_pulse && !ocp_set[0] |=> !ocp_lat_r[0])
        else $error("clearing pulse left overcurrent latched");
    AST_OT_SET: assert property (ot |=> ot_lat_r ##1 bridge_drive_o == 2'h0)
        else $error("overtemperature did not stop bridges");
    AST_OT_CLR: assert property (ot_lat_r && clr_pulse && !ot |=> !ot_lat_r)
        else $error("cooled overtemperature not cleared");
    AST_ASLEEP: assert property (asleep_r
        |-> !pump_en_o ##1 bridge_drive_o == 2'h0 && bridge_decay_o == 2'h0)
        else $error("transistors or pump on while asleep");
    AST_WAKE: assert property (asleep_r && wake_pin |=> !asleep_r)
        else $error("high sleep pin did not wake");
    AST_ACTIVE: assert property ($rose(bridge_drive_o[0]) |-> $past(ready_o))
        else $error("bridge driven while not active");
    AST_PUMP_UNDERVOLT_REC: assert property ($fell(pump_undervolt) && !uv && !ot_lat_r && ocp_lat_r == 2'h0
        |-> !fault_flag_out_oe_o)
        else $error("pump undervoltage did not release fault");
    AST_MASK1: assert property (st_r[1] == BFSS_MASK |=> st_r[1] != BFSS_DECAY)
        else $error("decay entered during blanking on bridge one");
    AST_OCP_HOLD: assert property (ocp_lat_r[0] && !clr_pulse |=> ocp_lat_r[0])
        else $error("overcurrent latch lost");
    AST_OT: assert property (ot_lat_r && ot |=> ot_lat_r && !pump_en_o)
        else $error("overtemperature released while hot");
    AST_SLEEP: assert property ($fell(wake_pin) |-> !asleep_r [*8])
        else $error("sleep entered without delay");
    AST_CLR: assert property (clr_pulse |-> $past(low_cnt_r) > 12'd399)
        else $error("fault cleared by too short a pulse");
    AST_CLR_MAX: assert property (clr_pulse |-> $past(low_cnt_r) < CLR_MAX)
        else $error("fault cleared by too long a low time");
    AST_CLR_PUMP: assert property (clr_pulse && !asleep_r && !uv && !ot_lat_r
        |-> pump_en_o)
        else $error("clearing pulse disturbed the pump");

    COV_DECAY: cover property (bridge_decay_o[0] ##1 bridge_drive_o[0]);
    COV_CLR: cover property (ocp_lat_r[0] ##1 clr_pulse ##1 !ocp_lat_r[0]);
    COV_SLEEP: cover property (asleep_r ##1 !asleep_r);
    COV_OT: cover property (ot_lat_r && !ot ##1 ot_clr);
    COV_OCP1: cover property (ocp_set[1] ##1 ocp_lat_r[1]);
endmodule : bfss_supervisor

/* sim/bfss_ctrl_model.sv */
// Motor controller model driving the sleep pin
`timescale 1ns/10ps
module bfss_ctrl_model (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        reset_i,
    // Commands from the bench
    input  wire logic        start_i,
    input  wire logic [11:0] low_cyc_i,
    // Sleep pin and status
    output logic             low_power_req_n_o,
    output logic             busy_o
);
    logic [11:0] cnt_r;
    // Pin held low for exactly the commanded cycle count, high otherwise
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            cnt_r <= 12'h0;
        end else if (start_i && cnt_r == 12'h0) begin
            cnt_r <= low_cyc_i;
        end else if (cnt_r != 12'h0) begin
            cnt_r <= cnt_r - 12'h1;
        end
    end
    assign low_power_req_n_o = (cnt_r == 12'h0);
    assign busy_o            = (cnt_r != 12'h0);
endmodule : bfss_ctrl_model

/* sim/bfss_supervisor_tb.sv */
// Self-checking testbench for the bridge fault and sleep supervisor
`timescale 1ns/10ps
module bfss_supervisor_tb;
    import bfss_pkg::*;
    logic        clk_i = 1'b0, reset_i = 1'b1, pulse_go = 1'b0;
    logic        supply_undervolt_i = 1'b0, pump_undervolt_i = 1'b0, overtemp_shutdown_i = 1'b0;
    logic [1:0]  ilim_i = 2'h0, trip_i = 2'h0, drive_req_i = 2'h0, decay_sel_i = 2'h0;
    logic [11:0] pulse_len = 12'h0;
    logic        low_power_req_n_i, ctl_busy, pump_en_o, asleep_o, ready_o;
    logic        overtemp_shutdown_o, fault_clear_o, fault_flag_out_o, fault_flag_out_oe_o;
    logic [1:0]  bridge_drive_o, bridge_decay_o, overcurrent_trip_o;
    int          error_cnt = 0, checked = 0;
    int          decay_interval[4] = '{140, 320, 480, 640};
    always #25 clk_i = ~clk_i;
    bfss_ctrl_model ctl (.clk_i, .reset_i, .start_i(pulse_go), .low_cyc_i(pulse_len),
        .low_power_req_n_o(low_power_req_n_i), .busy_o(ctl_busy));
    bfss_supervisor #(.OCP_FILT_CYC(4), .SLEEP_CYC(600)) uut (.clk_i, .reset_i,
        .low_power_req_n_i, .supply_undervolt_i, .pump_undervolt_i, .overtemp_shutdown_i,
        .ilim_i, .trip_i, .drive_req_i, .decay_sel_i, .bridge_drive_o, .bridge_decay_o,
        .pump_en_o, .asleep_o, .ready_o, .overcurrent_trip_o, .overtemp_shutdown_o,
        .fault_clear_o, .fault_flag_out_o, .fault_flag_out_oe_o);
    task automatic end_sim();
        $display("Checks %0d, errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : end_sim
    task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: %s got %0h expected %0h", $time, what, got, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_i);
    endtask : cyc
    task automatic wait_ready();
        int i;
        for (i = 0; i < 5000 && ready_o !== 1'b1; i++) cyc(1);
        chk(12'(ready_o), 12'h1, "ready");
        if (ready_o !== 1'b1) end_sim();
    endtask : wait_ready
    // Low pulse on the sleep pin, then look for the decoded clear strobe
    task automatic clear_pulse(input logic [11:0] len);
        int i;
        @(posedge clk_i);
        pulse_len <= len;
        pulse_go <= 1'b1;
        @(posedge clk_i);
        pulse_go <= 1'b0;
        for (i = 0; i < 1300 && fault_clear_o !== 1'b1; i++) cyc(1);
        chk(12'(fault_clear_o), 12'h1, "clear strobe");
        if (fault_clear_o !== 1'b1) end_sim();
        cyc(3);
    endtask : clear_pulse
    task automatic t_pwm();
        int i, on, off;
        wait_ready();
        for (i = 0; i < 4; i++) begin
            @(posedge clk_i);
            decay_sel_i <= 2'(i);
            trip_i <= 2'h1;
            drive_req_i <= 2'h1;
            for (on = 0; on < 50 && bridge_drive_o[0] !== 1'b1; on++) cyc(1);
            for (on = 0; on < 900 && bridge_drive_o[0] === 1'b1; on++) cyc(1);
            chk(12'(on >= 20), 12'h1, "mask time");
            for (off = 0; off < 900 && bridge_decay_o[0] === 1'b1; off++) cyc(1);
            chk(12'(off), 12'(decay_interval[i]), "decay time");
            @(posedge clk_i);
            drive_req_i <= 2'h0;
            cyc(5);
        end
        @(posedge clk_i);
        trip_i <= 2'h0;
        drive_req_i <= 2'h3;
    endtask : t_pwm
    task automatic t_uv();
        int k;
        for (k = 0; k < 2; k++) begin
            @(posedge clk_i);
            if (k == 0) supply_undervolt_i <= 1'b1;
            else pump_undervolt_i <= 1'b1;
            cyc(8);
            chk(12'(bridge_drive_o | bridge_decay_o), 12'h0, "bridges off");
            chk(12'(pump_en_o), 12'(k), "pump");
            chk(12'(fault_flag_out_oe_o), 12'h1, "fault pin");
            @(posedge clk_i);
            supply_undervolt_i <= 1'b0;
            pump_undervolt_i <= 1'b0;
            cyc(8);
            chk(12'(fault_flag_out_oe_o), 12'h0, "fault released");
            wait_ready();
            cyc(4);
            chk(12'(bridge_drive_o), 12'h3, "drive resumed");
        end
    endtask : t_uv
    task automatic t_ocp();
        @(posedge clk_i);
        ilim_i <= 2'h1;
        cyc(20);
        @(posedge clk_i);
        ilim_i <= 2'h0;
        cyc(20);
        chk(12'(overcurrent_trip_o), 12'h1, "ocp latch");
        chk(12'(bridge_drive_o), 12'h2, "other bridge");
        chk(12'({pump_en_o, fault_flag_out_oe_o}), 12'h3, "pump and pin");
        clear_pulse(12'd500);
        chk(12'({overcurrent_trip_o, fault_flag_out_oe_o}), 12'h0, "ocp cleared");
        chk(12'({pump_en_o, asleep_o}), 12'h2, "pump kept");
    endtask : t_ocp
    task automatic t_ot();
        @(posedge clk_i);
        overtemp_shutdown_i <= 1'b1;
        cyc(8);
        chk(12'({bridge_drive_o, pump_en_o, fault_flag_out_oe_o}), 12'h1, "ot off");
        clear_pulse(12'd500);
        chk(12'(overtemp_shutdown_o), 12'h1, "ot hot");
        @(posedge clk_i);
        overtemp_shutdown_i <= 1'b0;
        cyc(8);
        chk(12'(overtemp_shutdown_o), 12'h1, "ot cooled");
        clear_pulse(12'd1000);
        chk(12'({overtemp_shutdown_o, fault_flag_out_oe_o}), 12'h0, "ot cleared");
    endtask : t_ot
    task automatic t_sleep();
        int i;
        wait_ready();
        @(posedge clk_i);
        pulse_len <= 12'd1500;
        pulse_go <= 1'b1;
        @(posedge clk_i);
        pulse_go <= 1'b0;
        cyc(400);
        chk(12'(asleep_o), 12'h0, "sleep delayed");
        cyc(400);
        chk(12'({asleep_o, pump_en_o, bridge_drive_o, bridge_decay_o}), 12'h20, "asleep");
        for (i = 0; i < 2000 && ctl_busy === 1'b1; i++) cyc(1);
        chk(12'(ctl_busy), 12'h0, "pin released");
        if (ctl_busy !== 1'b0) end_sim();
        cyc(5);
        chk(12'(asleep_o), 12'h0, "woken");
        wait_ready();
    endtask : t_sleep
    initial begin
        repeat (20) @(posedge clk_i);
        reset_i <= 1'b0;
        cyc(2);
        chk(12'({fault_flag_out_o, fault_flag_out_oe_o}), 12'h0, "pin after reset");
        t_pwm();
        t_uv();
        t_ocp();
        t_ot();
        t_sleep();
        end_sim();
    end
endmodule : bfss_supervisor_tb
